// *** mem_port_map.vh ***
// register offsets, field positions, reset values and timing counts for the memory port
// assumes a 32-bit apb bus with byte addresses and one aligned word per register
`ifndef MEM_PORT_MAP_VH
`define MEM_PORT_MAP_VH

// ==========================================================================
// register offsets (byte addresses)
`define OFS_CTRL            8'h00
`define OFS_STATUS          8'h04
`define OFS_ISSUED          8'h08

// ==========================================================================
// control register fields
`define CTRL_ENABLE_BIT     0
`define CTRL_HOLD_LSB       1
`define CTRL_WDD_LSB        4
`define CTRL_BURST_LSB      8
`define CTRL_MERGE_BIT      12

// ==========================================================================
// control register reset values
`define RST_ENABLE          1'h1
`define RST_HOLD            2'h2
`define RST_WDD             2'h2
`define RST_BURST_CODE      2'h1
`define RST_MERGE           1'h0

// ==========================================================================
// status register fields
`define STAT_HOLD_BIT       0
`define STAT_DATA_BIT       1
`define STAT_BANK_BIT       2
`define STAT_ROW_BIT        3
`define STAT_WAIT_BIT       4

// ==========================================================================
// timing: shortest hold window in cycles, for a hold setting of zero
`define HOLD_BASE_CYCLES    4'h2
// number of in-flight write slots, covers the longest write-data delay
`define SLOT_COUNT          4

`endif

// *** mem_port_autohold_flow_control.v ***
// write side of the memory port: address issue, write-data beats and autohold spacing
// assumes the soft controller and the requester share sys_clk; apb slave with no wait states
//
// Added by the designer: the address map and the APB register port.
`include "mem_port_map.vh"

// Notes on behaviour
// - hold setting picks window length: 2'b00 two cycles, 2'b10 four cycles.
// - first write beat appears write-data-delay cycles after address valid.
// - one beat per cycle, consecutive, beat count equals configured burst length.
// - address with bank or row conflict opens an autohold window.
// - ready held through hold: next address after hold plus burst cycles.
// - hold setting zero: conflicted transactions spaced two plus burst cycles while ready stays high.
// - while controller ready is low no new transaction is issued.
// - with merge enabled, any partial byte-enable beat opens an autohold window.
// - byte enable width is data width over eight, four bits at 32 bits.
// - same-bank and same-row flags compare address with previous transaction.
module mem_port_autohold_flow_control #(
	parameter DW        = 128,                 // write data width
	parameter AW        = 32,                  // address width
	parameter MAXB      = 4,                   // longest burst, in beats
	parameter BANK_LSB  = 10,                  // lowest bank address bit
	parameter BANK_BITS = 3,                   // bank field width
	parameter ROW_LSB   = 13,                  // lowest row address bit
	parameter ROW_BITS  = 14                   // row field width
) (
	input  wire                 sys_clk,                // port clock
	input  wire                 reset,                  // async reset, active high
	// apb slave
	input  wire                 psel,                   // slave select
	input  wire                 penable,                // access phase
	input  wire                 pwrite,                 // write when high
	input  wire [7:0]           paddr,                  // byte address
	input  wire [31:0]          pwdata,                 // write data
	output wire                 pready,                 // always ready
	output reg  [31:0]          prdata,                 // read data
	output wire                 pslverr,                // unmapped address
	// requester side
	input  wire                 req_valid,              // transaction offered
	output wire                 req_ready,              // transaction taken this cycle
	input  wire [AW-1:0]        req_addr,               // transaction address
	input  wire [DW*MAXB-1:0]   req_data,               // all beats, beat 0 lowest
	input  wire [DW/8*MAXB-1:0] req_be,                 // all byte enables, beat 0 lowest
	// soft controller side
	input  wire                 ctrl_ready_to_accept,   // controller can take a transaction
	output reg                  port_address_valid,     // address strobe
	output reg  [AW-1:0]        port_address,           // address
	output reg                  same_bank_flag,         // same bank as previous
	output reg                  same_row_flag,          // same row as previous
	output reg  [DW-1:0]        port_write_data,        // write beat
	output reg                  port_write_data_valid,  // write beat valid
	output reg  [DW/8-1:0]      port_byte_enables,      // byte enables of beat
	output wire                 port_hold_active        // autohold window open
);

	localparam BW = DW / 8;
	localparam [BW-1:0] BE_FULL = {BW{1'b1}};

	// ==========================================================================
	// functions

	function [3:0] hold_cycles;
		input [1:0] setting;
		begin
			hold_cycles = `HOLD_BASE_CYCLES + {2'h0, setting};
		end
	endfunction

	// any beat within the burst that leaves a byte unwritten
	function partial_write;
		input [BW*MAXB-1:0] be;
		input [2:0]         len;
		integer i;
		begin
			partial_write = 1'b0;
			for (i = 0; i < MAXB; i = i + 1)
			begin
				if ((i < len) && (be[i*BW +: BW] != BE_FULL))
					partial_write = 1'b1;
			end
		end
	endfunction

	// ==========================================================================
	// control registers

	reg         enable_reg;
	reg  [1:0]  hold_reg;
	reg  [1:0]  wdd_reg;
	reg  [1:0]  burst_code_reg;
	reg         merge_reg;
	reg  [31:0] issued_reg;

	wire [2:0]  burst_len = {1'b0, burst_code_reg} + 3'h1;
	wire        apb_write = psel & penable & pwrite;
	wire        addr_ok   = (paddr == `OFS_CTRL) || (paddr == `OFS_STATUS) ||
	                        (paddr == `OFS_ISSUED);

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;

	always @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			enable_reg     <= `RST_ENABLE;
			hold_reg       <= `RST_HOLD;
			wdd_reg        <= `RST_WDD;
			burst_code_reg <= `RST_BURST_CODE;
			merge_reg      <= `RST_MERGE;
		end
		else if (apb_write && (paddr == `OFS_CTRL))
		begin
			enable_reg     <= pwdata[`CTRL_ENABLE_BIT];
			hold_reg       <= pwdata[`CTRL_HOLD_LSB +: 2];
			wdd_reg        <= pwdata[`CTRL_WDD_LSB +: 2];
			burst_code_reg <= pwdata[`CTRL_BURST_LSB +: 2];
			merge_reg      <= pwdata[`CTRL_MERGE_BIT];
		end
	end

	// ==========================================================================
	// issue control

	reg  [3:0]    gap_reg;
	reg           hold_open_reg;
	reg  [AW-1:0] prev_addr_reg;
	reg           have_prev_reg;
	reg  [1:0]    wr_ptr_reg;
	reg  [1:0]    rd_ptr_reg;

	wire bank_hit = have_prev_reg &&
	                (req_addr[BANK_LSB +: BANK_BITS] == prev_addr_reg[BANK_LSB +: BANK_BITS]);
	wire row_hit  = have_prev_reg &&
	                (req_addr[ROW_LSB +: ROW_BITS] == prev_addr_reg[ROW_LSB +: ROW_BITS]);
	wire part_hit = merge_reg && partial_write(req_be, burst_len);
	wire autohold = bank_hit | row_hit | part_hit;

	// ready is sampled as the address would go out
	wire issue = enable_reg & req_valid & ctrl_ready_to_accept & (gap_reg == 4'h0);

	assign req_ready        = issue;
	assign port_hold_active = hold_open_reg;

	always @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			gap_reg            <= 4'h0;
			hold_open_reg      <= 1'b0;
			prev_addr_reg      <= {AW{1'b0}};
			have_prev_reg      <= 1'b0;
			port_address_valid <= 1'b0;
			port_address       <= {AW{1'b0}};
			same_bank_flag     <= 1'b0;
			same_row_flag      <= 1'b0;
			issued_reg         <= 32'h0;
		end
		else
		begin
			port_address_valid <= issue;
			if (issue)
			begin
				port_address   <= req_addr;
				// flags compare with the previous transaction
				same_bank_flag <= bank_hit;
				same_row_flag  <= row_hit;
				prev_addr_reg  <= req_addr;
				have_prev_reg  <= 1'b1;
				issued_reg     <= issued_reg + 32'h1;
				hold_open_reg  <= autohold;
				// conflict or partial write widens the spacing
				// partial write counts only with merge enabled
				// spacing is hold plus burst when ready stays high
				// hold setting zero still adds two cycles
				// counted from the address cycle itself
				if (autohold)
					gap_reg <= hold_cycles(hold_reg) + {1'b0, burst_len} - 4'h1;
				else
					gap_reg <= {1'b0, burst_len} - 4'h1;
			end
			else if (gap_reg != 4'h0)
			begin
				gap_reg <= gap_reg - 4'h1;
			end
			else
			begin
				hold_open_reg <= 1'b0;
			end
		end
	end

	// ==========================================================================
	// in-flight write slots
	// issue spacing of a full burst bounds the slots in use by delay plus one

	reg [DW*MAXB-1:0] slot_data [0:`SLOT_COUNT-1];
	reg [BW*MAXB-1:0] slot_be   [0:`SLOT_COUNT-1];

	always @(posedge sys_clk)
	begin
		if (issue)
		begin
			slot_data[wr_ptr_reg] <= req_data;
			slot_be[wr_ptr_reg]   <= req_be;
		end
	end

	// ==========================================================================
	// write data beats

	reg  [2:0] start_pipe_reg;
	reg        active_reg;
	reg  [1:0] beat_reg;

	// data starts write-data-delay cycles after the address strobe
	wire start_now = (wdd_reg == 2'h0) ? issue : start_pipe_reg[wdd_reg - 2'h1];
	wire beat_go   = start_now | active_reg;
	wire [1:0] cur_beat = active_reg ? beat_reg : 2'h0;
	wire last_beat = ({1'b0, cur_beat} == (burst_len - 3'h1));

	always @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			start_pipe_reg        <= 3'h0;
			active_reg            <= 1'b0;
			beat_reg              <= 2'h0;
			wr_ptr_reg            <= 2'h0;
			rd_ptr_reg            <= 2'h0;
			port_write_data       <= {DW{1'b0}};
			port_write_data_valid <= 1'b0;
			port_byte_enables     <= {BW{1'b0}};
		end
		else
		begin
			start_pipe_reg        <= {start_pipe_reg[1:0], issue};
			port_write_data_valid <= beat_go;
			if (issue)
				wr_ptr_reg <= wr_ptr_reg + 2'h1;
			if (beat_go)
			begin
				// one beat per cycle until the burst length is reached
				// byte enables are one bit per data byte
				port_write_data   <= slot_data[rd_ptr_reg][cur_beat*DW +: DW];
				port_byte_enables <= slot_be[rd_ptr_reg][cur_beat*BW +: BW];
				if (last_beat)
				begin
					active_reg <= 1'b0;
					beat_reg   <= 2'h0;
					rd_ptr_reg <= rd_ptr_reg + 2'h1;
				end
				else
				begin
					active_reg <= 1'b1;
					beat_reg   <= cur_beat + 2'h1;
				end
			end
			else
			begin
				port_byte_enables <= {BW{1'b0}};
			end
		end
	end

	// ==========================================================================
	// apb read data, captured in the setup phase so the access phase sees it

	reg [31:0] read_mux;

	always @*
	begin
		read_mux = 32'h0;
		case (paddr)
			`OFS_CTRL:
			begin
				read_mux[`CTRL_ENABLE_BIT]      = enable_reg;
				read_mux[`CTRL_HOLD_LSB +: 2]   = hold_reg;
				read_mux[`CTRL_WDD_LSB +: 2]    = wdd_reg;
				read_mux[`CTRL_BURST_LSB +: 2]  = burst_code_reg;
				read_mux[`CTRL_MERGE_BIT]       = merge_reg;
			end
			`OFS_STATUS:
			begin
				read_mux[`STAT_HOLD_BIT] = hold_open_reg;
				read_mux[`STAT_DATA_BIT] = active_reg | (start_pipe_reg != 3'h0);
				read_mux[`STAT_BANK_BIT] = same_bank_flag;
				read_mux[`STAT_ROW_BIT]  = same_row_flag;
				read_mux[`STAT_WAIT_BIT] = req_valid & ~ctrl_ready_to_accept;
			end
			`OFS_ISSUED:
				read_mux = issued_reg;
			default:
				read_mux = 32'h0;
		endcase
	end

	always @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			prdata <= 32'h0;
		else if (psel && !penable)
			prdata <= read_mux;
	end

endmodule // mem_port_autohold_flow_control

// *** mem_port_props.sv ***
// assertions on the write side of the memory port
// assumes write-data delay 2 and burst length 2 throughout the run
module mem_port_props #(parameter DW = 32) (
	input logic          sys_clk,               // clock
	input logic          reset,                 // async reset
	input logic          req_valid,             // offer
	input logic          req_ready,             // taken
	input logic          ctrl_ready_to_accept,  // controller ready
	input logic          port_address_valid,    // address strobe
	input logic          same_bank_flag,        // bank flag
	input logic          same_row_flag,         // row flag
	input logic          port_write_data_valid, // beat valid
	input logic [DW/8-1:0] port_byte_enables,   // beat enables
	input logic          port_hold_active       // window open
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	wire cf = port_address_valid && (same_bank_flag || same_row_flag);
	// ==========================================
	// properties
	property p_first_beat;
		port_address_valid |-> ##2 port_write_data_valid;
	endproperty
	a_first_beat: assert property (p_first_beat) else $error("late beat");
	property p_beat_pair;
		$rose(port_write_data_valid) |=> port_write_data_valid;
	endproperty
	a_beat_pair: assert property (p_beat_pair) else $error("short burst");
	property p_spacing;
		port_address_valid |=> !port_address_valid;
	endproperty
	a_spacing: assert property (p_spacing) else $error("addresses too close");
	property p_conf_gap;
		cf |=> !port_address_valid [*3];
	endproperty
	a_conf_gap: assert property (p_conf_gap) else $error("conflict gap short");
	property p_hold_on;
		cf |-> ##[0:1] port_hold_active;
	endproperty
	a_hold_on: assert property (p_hold_on) else $error("no hold window");
	property p_ready_gate;
		req_ready |-> req_valid && ctrl_ready_to_accept;
	endproperty
	a_ready_gate: assert property (p_ready_gate) else $error("taken while blocked");
	property p_low_blocks;
		!ctrl_ready_to_accept |=> !port_address_valid;
	endproperty
	a_low_blocks: assert property (p_low_blocks) else $error("issued while blocked");
	property p_issue_cause;
		port_address_valid |-> $past(req_ready);
	endproperty
	a_issue_cause: assert property (p_issue_cause) else $error("issue not taken");
	property p_be_idle;
		!port_write_data_valid |-> !(|port_byte_enables);
	endproperty
	a_be_idle: assert property (p_be_idle) else $error("enables without beat");
endmodule // mem_port_props

bind mem_port_autohold_flow_control mem_port_props #(.DW(DW)) u_mem_port_props (.sys_clk,
	.reset, .req_valid, .req_ready, .ctrl_ready_to_accept, .port_address_valid,
	.same_bank_flag, .same_row_flag, .port_write_data_valid, .port_byte_enables,
	.port_hold_active);

// *** soft_ctrl_model.sv ***
// soft memory controller model driving ready-to-accept
// assumes the bench sets drop delay and length while the port is idle
module soft_ctrl_model (
	input logic        sys_clk,              // clock
	input logic        reset,                // async reset
	input logic        port_address_valid,   // address strobe
	input logic        same_bank_flag,       // bank flag
	input logic        same_row_flag,        // row flag
	input logic [3:0]  drop_delay,           // cycles before drop
	input logic [3:0]  drop_len,             // cycles held low, 0 never
	output logic       ctrl_ready_to_accept  // ready to accept
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt;
	always @(posedge sys_clk or posedge reset)
		if (reset)
			cnt <= 4'h0;
		else if (port_address_valid && (same_bank_flag || same_row_flag))
			cnt <= 4'h1;
		else if (cnt != 4'h0 && cnt != 4'hF)
			cnt <= cnt + 4'h1;
	assign ctrl_ready_to_accept = !(cnt > drop_delay && cnt <= drop_delay + drop_len);
endmodule // soft_ctrl_model

// *** mem_port_autohold_flow_control_bench.sv ***
// self-checking bench for the memory port write side
// apb and requester driven here, controller model on the far side
module mem_port_autohold_flow_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, req_valid = 0;
	logic pready, pslverr, req_ready, port_address_valid, same_bank_flag, same_row_flag;
	logic port_write_data_valid, port_hold_active, ctrl_ready_to_accept;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, req_addr = 32'h0, prdata, port_address, port_write_data;
	logic [127:0] req_data = 128'h0;
	logic [15:0] req_be = 16'h0;
	logic [3:0] port_byte_enables, drop_delay = 4'h1, drop_len = 4'h0;
	int err_count = 0, checked = 0, cyc = 0, n_av = 0, k = 0, sent = 0;
	int av [0:31];
	logic [1:0] fl [0:31];
	logic [31:0] pa [0:31];
	logic [36:0] wd [0:1023];
	mem_port_autohold_flow_control #(.DW(32)) u_mem_port_autohold_flow_control (.sys_clk,
		.reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
		.req_valid, .req_ready, .req_addr, .req_data, .req_be, .ctrl_ready_to_accept,
		.port_address_valid, .port_address, .same_bank_flag, .same_row_flag,
		.port_write_data, .port_write_data_valid, .port_byte_enables, .port_hold_active);
	soft_ctrl_model u_soft_ctrl_model (.sys_clk, .reset, .port_address_valid,
		.same_bank_flag, .same_row_flag, .drop_delay, .drop_len, .ctrl_ready_to_accept);
	always #5 sys_clk = ~sys_clk;
	// ==========================================
	// monitor: issue times, flags and beats
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		wd[cyc % 1024] <= {port_write_data_valid, port_byte_enables, port_write_data};
		if (port_address_valid)
		begin
			av[n_av % 32] <= cyc;
			fl[n_av % 32] <= {same_bank_flag, same_row_flag};
			pa[n_av % 32] <= port_address;
			n_av <= n_av + 1;
		end
	end
	task automatic print_verdict;
		if (err_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [36:0] got, input logic [36:0] exp);
		checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		// idle edge so a following call never reassigns psel in this time step
		@(posedge sys_clk);
		if (n >= 50)
		begin
			err_count++;
			print_verdict;
		end
	endtask
	// fresh addresses differ from the last in bank and row; dup repeats it
	task automatic send(input logic dup, input logic [15:0] be);
		int n;
		if (!dup)
			k++;
		sent++;
		req_addr <= {k[18:0], k[2:0], 10'h000};
		req_be <= be;
		req_data <= {4{k}};
		req_valid <= 1;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end while (req_ready !== 1'h1 && n < 100);
		if (n >= 100)
		begin
			err_count++;
			print_verdict;
		end
	endtask
	task automatic trio(input logic [31:0] ctrl, input logic dup, input logic [15:0] be2,
		output int b);
		logic [31:0] r;
		logic e;
		apb(1, 8'h00, ctrl, r, e);
		b = n_av;
		send(0, 16'hFFFF);
		send(dup, be2);
		send(0, 16'hFFFF);
		req_valid <= 0;
		repeat (16) @(posedge sys_clk);
		chk(av[b % 32 + 1] - av[b % 32], 2);
		chk(pa[b % 32 + 2], {k[18:0], k[2:0], 10'h000});
		apb(0, 8'h08, 32'h0, r, e);
		chk({e, r}, {1'h0, sent});
		b = b % 32;
	endtask
	// ==========================================
	// scenarios
	task automatic reg_access;
		logic [31:0] r;
		logic e;
		apb(0, 8'h00, 32'h0, r, e);
		chk({e, r}, {1'h0, 32'h125});
		apb(0, 8'h04, 32'h0, r, e);
		chk({e, r}, {1'h0, 32'h0});
		apb(0, 8'h0C, 32'h0, r, e);
		chk({e, r}, {1'h1, 32'h0});
	endtask
	task automatic hold_codes;
		int b;
		for (int c = 0; c < 4; c++)
		begin
			trio(32'h121 | (c << 1), 1, 16'hFFFF, b);
			chk(av[b + 2] - av[b + 1], c + 4);
			chk({fl[b], fl[b + 1], fl[b + 2]}, 6'h0C);
			chk(wd[(av[b] + 2) % 1024], {1'h1, 4'hF, 32'(k - 1)});
			chk(wd[(av[b] + 3) % 1024], {1'h1, 4'hF, 32'(k - 1)});
		end
	endtask
	task automatic ready_drop;
		int b;
		drop_len <= 4'h5;
		trio(32'h125, 1, 16'hFFFF, b);
		chk(av[b + 2] - av[b + 1], 8);
		// zero hold: a drop before the issue point is still seen
		trio(32'h121, 1, 16'hFFFF, b);
		chk(av[b + 2] - av[b + 1], 8);
		// zero hold: a drop after the issue point is missed
		drop_delay <= 4'h3;
		trio(32'h121, 1, 16'hFFFF, b);
		chk(av[b + 2] - av[b + 1], 4);
		drop_len <= 4'h0;
		drop_delay <= 4'h1;
	endtask
	task automatic merge_partial;
		int b;
		trio(32'h1125, 0, 16'hFFF4, b);
		chk(av[b + 2] - av[b + 1], 6);
		chk(wd[(av[b + 1] + 2) % 1024], {1'h1, 4'h4, 32'(k - 1)});
	endtask
	initial
	begin
		repeat (3) @(posedge sys_clk);
		reset <= 0;
		reg_access;
		hold_codes;
		ready_drop;
		merge_partial;
		print_verdict;
	end
endmodule // mem_port_autohold_flow_control_bench
